// *** vic_regs.vh ***
`ifndef VIC_REGS_VH
`define VIC_REGS_VH

// register byte addresses, and the vector table address mask
`define VIC_SVR_BASE 32'hFFFF_F080
`define VIC_SVR_MASK 32'hFFFF_FF80
`define VIC_NORMAL_VECTOR_READ 32'hFFFF_F100
`define VIC_FAST_VECTOR_READ 32'hFFFF_F104
`define VIC_CURRENT_ID 32'hFFFF_F108
`define VIC_PENDING_STATE 32'hFFFF_F10C
`define VIC_SOURCE_ENABLE_STATE 32'hFFFF_F110
`define VIC_CORE_REQUEST_STATE 32'hFFFF_F114
`define VIC_SOURCE_ENABLE_COMMAND 32'hFFFF_F120
`define VIC_SOURCE_DISABLE_COMMAND 32'hFFFF_F124
`define VIC_PENDING_CLEAR_COMMAND 32'hFFFF_F128
`define VIC_PENDING_SET_COMMAND 32'hFFFF_F12C
`define VIC_END_OF_SERVICE_COMMAND 32'hFFFF_F130
`define VIC_SPURIOUS_VECTOR 32'h0FFF_F134
`define VIC_DEBUG_CONTROL 32'hFFFF_F138
`define VIC_FAST_FORCING_ENABLE_COMMAND 32'hFFFF_F140
`define VIC_FAST_FORCING_DISABLE_COMMAND 32'hFFFF_F144
`define VIC_FAST_FORCING_STATE 32'hFFFF_F148

// field positions
`define VIC_FAST_SOURCE_BIT 0
`define VIC_SYSTEM_SOURCE_BIT 1
`define VIC_PROTECTION_MODE_BIT 0
`define VIC_GENERAL_MASK_BIT 1
`define VIC_CORE_FAST_BIT 0
`define VIC_CORE_NORMAL_BIT 1
`define VIC_VEC_IDX_MSB 6
`define VIC_VEC_IDX_LSB 2

// reset values, and the mask of forcing bits in use
`define VIC_ENABLE_RST 32'h0000_0000
`define VIC_PENDING_RST 32'h0000_0000
`define VIC_FORCING_RST 32'h0000_0000
`define VIC_SPURIOUS_RST 32'h0000_0000
`define VIC_DEBUG_RST 2'h0
`define VIC_FORCING_USED 32'hFFFF_FFFE

`endif

// *** vic_vec_mem.v ***
`timescale 1ns/100ps
module vic_vec_mem #(
    parameter WIDTH = 32,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    input wire clk_i,
    input wire wr_en_i,
    input wire [AW-1:0] wr_addr_i,
    input wire [WIDTH-1:0] wr_data_i,
    input wire [AW-1:0] rd_addr_i,
    output reg [WIDTH-1:0] rd_data_o
);
    reg [WIDTH-1:0] mem_reg [0:DEPTH-1];

    always @(posedge clk_i) begin
        if (wr_en_i) begin
            mem_reg[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem_reg[rd_addr_i];
    end
endmodule // vic_vec_mem

// *** vic_top.v ***
// What this block does
// - enable command write sets the enable of each source written as one
// - disable command write clears the enable of each source written as one
// - clear command write drops pending of each source written as one
// - set command write makes each source written as one pending
// - bit 0 fast source, bit 1 system source, bits 2-31 peripherals
// - any write to end-of-service register ends current interrupt handling
// - spurious vector is a 32-bit read/write software store
// - spurious normal interrupt reads back the spurious vector
// - spurious fast interrupt reads back the spurious vector
// - debug bit 0 is protection mode, read/write
// - debug bit 1 forces both request outputs inactive
// - fast forcing enable command turns forcing on, bit 0 unused
// - normal vector read with no current interrupt returns spurious vector
// - enable state register shows one per enabled source
// - forcing disable command turns forcing off; forcing state readable
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/100ps
`include "vic_regs.vh"
module vic_top #(
    parameter NSRC = 32
) (
    input wire CLK_I,
    input wire RESETN_I,
    input wire [31:0] PADDR_I,
    input wire PSEL_I,
    input wire PENABLE_I,
    input wire PWRITE_I,
    input wire [31:0] PWDATA_I,
    output wire [31:0] PRDATA_O,
    output wire PREADY_O,
    output wire PSLVERR_O,
    input wire [NSRC-1:0] SOURCE_I,
    output wire NORMAL_REQUEST_OUT_N_O,
    output wire FAST_REQUEST_OUT_N_O
);
    // lowest-numbered set bit wins
    function [4:0] first_set;
        input [31:0] v;
        integer i;
        begin
            first_set = 5'h00;
            for (i = 31; i >= 0; i = i - 1) begin
                if (v[i]) begin
                    first_set = i[4:0];
                end
            end
        end
    endfunction

    // word index of a source vector inside the table
    function [4:0] vec_index;
        input [31:0] addr;
        begin
            vec_index = addr[`VIC_VEC_IDX_MSB:`VIC_VEC_IDX_LSB];
        end
    endfunction

    // two-flop synchroniser, then a rising-edge detector per source
    reg [NSRC-1:0] src_meta_reg;
    reg [NSRC-1:0] src_sync_reg;
    reg [NSRC-1:0] src_prev_reg;
    reg [NSRC-1:0] pending_reg;
    reg [NSRC-1:0] pending_next;
    reg [NSRC-1:0] enable_reg;
    reg [NSRC-1:0] enable_next;
    reg [NSRC-1:0] forcing_reg;
    reg [NSRC-1:0] forcing_next;
    reg [31:0] spurious_reg;
    reg [1:0] debug_reg;
    reg in_service_reg;
    reg [4:0] cur_id_reg;
    reg [4:0] snap_id_reg;
    reg snap_valid_reg;
    // bus handshake states: the first access cycle, in idle, is the single wait state; the answer cycle completes
    localparam BUS_IDLE = 1'b0;
    localparam BUS_ANSWER = 1'b1;

    reg bus_state_reg;
    reg bus_state_next;
    reg in_service_next;
    reg [4:0] cur_id_next;
    reg [31:0] prdata_reg;
    reg normal_request_out_n_n_reg;
    reg fast_request_out_n_n_reg;

    wire [31:0] vec_rd_data;
    // the answer comes in the second access cycle
    wire access = PSEL_I & PENABLE_I;
    wire answering = bus_state_reg == BUS_ANSWER;
    wire first_access = access & ~answering;
    wire done = access & answering;
    wire wr_done = done & PWRITE_I;
    wire rd_done = done & ~PWRITE_I;
    wire protection_mode_bit = debug_reg[`VIC_PROTECTION_MODE_BIT];
    wire gmask = debug_reg[`VIC_GENERAL_MASK_BIT];

    // full 32-bit decode except the vector table, masked with VIC_SVR_MASK; anything else answers with an error
    wire is_svr = (PADDR_I & `VIC_SVR_MASK) == `VIC_SVR_BASE;
    wire is_ivr = PADDR_I == `VIC_NORMAL_VECTOR_READ;
    wire is_fvr = PADDR_I == `VIC_FAST_VECTOR_READ;
    wire is_isr = PADDR_I == `VIC_CURRENT_ID;
    wire is_ipr = PADDR_I == `VIC_PENDING_STATE;
    wire is_imr = PADDR_I == `VIC_SOURCE_ENABLE_STATE;
    wire is_cisr = PADDR_I == `VIC_CORE_REQUEST_STATE;
    wire is_iecr = PADDR_I == `VIC_SOURCE_ENABLE_COMMAND;
    wire is_idcr = PADDR_I == `VIC_SOURCE_DISABLE_COMMAND;
    wire is_iccr = PADDR_I == `VIC_PENDING_CLEAR_COMMAND;
    wire is_iscr = PADDR_I == `VIC_PENDING_SET_COMMAND;
    wire is_eoi = PADDR_I == `VIC_END_OF_SERVICE_COMMAND;
    wire is_spu = PADDR_I == `VIC_SPURIOUS_VECTOR;
    wire is_dcr = PADDR_I == `VIC_DEBUG_CONTROL;
    wire is_ffer = PADDR_I == `VIC_FAST_FORCING_ENABLE_COMMAND;
    wire is_ffdr = PADDR_I == `VIC_FAST_FORCING_DISABLE_COMMAND;
    wire is_ffsr = PADDR_I == `VIC_FAST_FORCING_STATE;
    wire mapped = is_svr | is_ivr | is_fvr | is_isr | is_ipr | is_imr | is_cisr | is_iecr | is_idcr
        | is_iccr | is_iscr | is_eoi | is_spu | is_dcr | is_ffer | is_ffdr | is_ffsr;

    // fast source never joins the normal request, forced sources go fast
    wire [NSRC-1:0] live = pending_reg & enable_reg;
    wire [NSRC-1:0] normal_set = live & ~(forcing_reg | {{(NSRC-1){1'b0}}, 1'b1});
    wire [NSRC-1:0] fast_set = live & (forcing_reg | {{(NSRC-1){1'b0}}, 1'b1});
    wire [31:0] normal_set_w = normal_set;
    wire cand_valid = |normal_set;
    wire [4:0] cand_id = first_set(normal_set_w);
    wire fast_valid = |fast_set;
    wire irq_active = cand_valid & ~in_service_reg;

    // acknowledge by reading the normal vector, or by writing it in protection mode
    wire normal_ack = (rd_done & is_ivr & ~protection_mode_bit) | (wr_done & is_ivr & protection_mode_bit);
    wire take_service = normal_ack & ~in_service_reg & snap_valid_reg;
    wire fast_ack = rd_done & is_fvr & ~protection_mode_bit;

    wire [4:0] rd_idx = is_ivr ? (in_service_reg ? cur_id_reg : cand_id) :
        is_fvr ? 5'h00 : vec_index(PADDR_I);

    // source vector table; read data is registered, hence the wait state
    vic_vec_mem #(
        .WIDTH(32),
        .DEPTH(32),
        .AW(5)
    ) u_vec_mem (
        .clk_i(CLK_I),
        .wr_en_i(wr_done & is_svr),
        .wr_addr_i(vec_index(PADDR_I)),
        .wr_data_i(PWDATA_I),
        .rd_addr_i(rd_idx),
        .rd_data_o(vec_rd_data)
    );

    // one wait state: vector memory answers a cycle after the address
    assign PREADY_O = done;
    assign PSLVERR_O = done & ~mapped;
    assign PRDATA_O = prdata_reg;
    assign NORMAL_REQUEST_OUT_N_O = normal_request_out_n_n_reg;
    assign FAST_REQUEST_OUT_N_O = fast_request_out_n_n_reg;

    // read mux, frozen into prdata_reg on the first access cycle
    reg [31:0] rd_value;
    always @* begin
        rd_value = 32'h0000_0000;
        if (is_svr) begin
            rd_value = vec_rd_data;
        end else if (is_ivr) begin
            if (in_service_reg | cand_valid) begin
                rd_value = vec_rd_data;
            end else begin
                rd_value = spurious_reg;
            end
        end else if (is_fvr) begin
            if (fast_valid) begin
                rd_value = vec_rd_data;
            end else begin
                rd_value = spurious_reg;
            end
        end else if (is_isr) begin
            rd_value = {{27{1'b0}}, cur_id_reg};
        end else if (is_ipr) begin
            rd_value = pending_reg;
        end else if (is_imr) begin
            rd_value = enable_reg;
        end else if (is_cisr) begin
            rd_value = {{30{1'b0}}, ~normal_request_out_n_n_reg, ~fast_request_out_n_n_reg};
        end else if (is_spu) begin
            rd_value = spurious_reg;
        end else if (is_dcr) begin
            rd_value = {{30{1'b0}}, debug_reg};
        end else if (is_ffsr) begin
            rd_value = forcing_reg;
        end
    end

    // command writes apply every bit in one cycle; zeros leave state alone
    always @* begin
        enable_next = enable_reg;
        if (wr_done & is_iecr) begin
            enable_next = enable_reg | PWDATA_I[NSRC-1:0];
        end
        if (wr_done & is_idcr) begin
            enable_next = enable_reg & ~PWDATA_I[NSRC-1:0];
        end
    end

    // bit 0 is fast already, so forcing it is ignored
    always @* begin
        forcing_next = forcing_reg;
        if (wr_done & is_ffer) begin
            forcing_next = forcing_reg | (PWDATA_I[NSRC-1:0] & `VIC_FORCING_USED);
        end
        if (wr_done & is_ffdr) begin
            forcing_next = forcing_reg & ~PWDATA_I[NSRC-1:0];
        end
    end

    // pending: edge or set command raises, clear or acknowledge drops
    reg [NSRC-1:0] pend_clr;
    reg [NSRC-1:0] pend_set;
    always @* begin
        pend_clr = {NSRC{1'b0}};
        pend_set = src_sync_reg & ~src_prev_reg;
        if (wr_done & is_iccr) begin
            pend_clr = PWDATA_I[NSRC-1:0];
        end
        if (wr_done & is_iscr) begin
            pend_set = pend_set | PWDATA_I[NSRC-1:0];
        end
        if (take_service) begin
            pend_clr[snap_id_reg] = 1'b1;
        end
        if (fast_ack) begin
            pend_clr = pend_clr | fast_set;
        end
        // a new edge or set in the clearing cycle survives
        pending_next = (pending_reg & ~pend_clr) | pend_set;
    end

    // synchroniser flops carry no reset; pending is cleared during reset anyway
    always @(posedge CLK_I) begin
        src_meta_reg <= SOURCE_I;
        src_sync_reg <= src_meta_reg;
        src_prev_reg <= src_sync_reg;
    end

    // handshake steps from idle to answer on the first access cycle
    always @* begin
        bus_state_next = BUS_IDLE;
        case (bus_state_reg)
            BUS_IDLE: begin
                if (access) begin
                    bus_state_next = BUS_ANSWER;
                end
            end
            BUS_ANSWER: begin
                bus_state_next = BUS_IDLE;
            end
            default: begin
                bus_state_next = BUS_IDLE;
            end
        endcase
    end

    // service level: entered by acknowledge, left by any end-of-service write
    always @* begin
        in_service_next = in_service_reg;
        cur_id_next = cur_id_reg;
        if (wr_done & is_eoi) begin
            in_service_next = 1'b0;
        end else if (take_service) begin
            in_service_next = 1'b1;
            cur_id_next = snap_id_reg;
        end
    end

    // bus handshake and read snapshot; the candidate is frozen with the data
    always @(posedge CLK_I) begin
        if (!RESETN_I) begin
            bus_state_reg <= BUS_IDLE;
            prdata_reg <= 32'h0000_0000;
            snap_id_reg <= 5'h00;
            snap_valid_reg <= 1'b0;
        end else begin
            bus_state_reg <= bus_state_next;
            if (first_access) begin
                prdata_reg <= PWRITE_I ? 32'h0000_0000 : rd_value;
                snap_id_reg <= cand_id;
                snap_valid_reg <= cand_valid;
            end
        end
    end

    // per-source state: pending, enable and fast forcing
    always @(posedge CLK_I) begin
        if (!RESETN_I) begin
            pending_reg <= `VIC_PENDING_RST;
            enable_reg <= `VIC_ENABLE_RST;
            forcing_reg <= `VIC_FORCING_RST;
        end else begin
            pending_reg <= pending_next;
            enable_reg <= enable_next;
            forcing_reg <= forcing_next;
        end
    end

    // software stores: spurious vector and debug control
    always @(posedge CLK_I) begin
        if (!RESETN_I) begin
            spurious_reg <= `VIC_SPURIOUS_RST;
            debug_reg <= `VIC_DEBUG_RST;
        end else begin
            if (wr_done & is_spu) begin
                spurious_reg <= PWDATA_I;
            end
            if (wr_done & is_dcr) begin
                debug_reg <= PWDATA_I[1:0];
            end
        end
    end

    // single service level, no nesting
    always @(posedge CLK_I) begin
        if (!RESETN_I) begin
            in_service_reg <= 1'b0;
            cur_id_reg <= 5'h00;
        end else begin
            in_service_reg <= in_service_next;
            cur_id_reg <= cur_id_next;
        end
    end

    // request lines are registered so they never glitch towards the core
    always @(posedge CLK_I) begin
        if (!RESETN_I) begin
            normal_request_out_n_n_reg <= 1'b1;
            fast_request_out_n_n_reg <= 1'b1;
        end else begin
            normal_request_out_n_n_reg <= ~(irq_active & ~gmask);
            fast_request_out_n_n_reg <= ~(fast_valid & ~gmask);
        end
    end
endmodule // vic_top

// *** icr_monitor.sv ***
`timescale 1ns/100ps
`include "vic_regs.vh"
module icr_monitor (
    input wire CLK_I,
    input wire RESETN_I,
    input wire [31:0] PADDR_I,
    input wire PSEL_I,
    input wire PENABLE_I,
    input wire PWRITE_I,
    input wire [31:0] PRDATA_O,
    input wire PREADY_O,
    input wire PSLVERR_O,
    input wire [31:0] PWDATA_I,
    input wire NORMAL_REQUEST_OUT_N_O,
    input wire FAST_REQUEST_OUT_N_O
);
    reg [31:0] en_reg;
    reg [31:0] spur_reg;
    reg general_mask_bit_reg;
    reg used_reg;
    wire wr = PREADY_O && PWRITE_I;
    wire rd = PREADY_O && !PWRITE_I;
    always @(posedge CLK_I) begin
        if (!RESETN_I) begin
            en_reg <= 32'h0000_0000;
            spur_reg <= 32'h0000_0000;
            general_mask_bit_reg <= 1'b0;
            used_reg <= 1'b0;
        end else if (wr) begin
            if (PADDR_I == `VIC_SOURCE_ENABLE_COMMAND) en_reg <= en_reg | PWDATA_I;
            if (PADDR_I == `VIC_SOURCE_DISABLE_COMMAND) en_reg <= en_reg & ~PWDATA_I;
            if (PADDR_I == `VIC_SOURCE_ENABLE_COMMAND) used_reg <= used_reg | (PWDATA_I != 32'h0000_0000);
            if (PADDR_I == `VIC_SPURIOUS_VECTOR) spur_reg <= PWDATA_I;
            if (PADDR_I == `VIC_DEBUG_CONTROL) general_mask_bit_reg <= PWDATA_I[1];
        end
    end
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESETN_I);
    sequence s_setup; PSEL_I && !PENABLE_I; endsequence
    sequence s_wait; PSEL_I && PENABLE_I && !PREADY_O; endsequence
    a_one_wait: assert property (s_setup ##1 PSEL_I && PENABLE_I |-> s_wait ##1 PREADY_O)
        else $error("ready not on second access cycle");
    a_ready_gated: assert property (PREADY_O |-> PSEL_I && PENABLE_I ##1 !PREADY_O)
        else $error("ready outside access or longer than one cycle");
    a_err_with_ready: assert property (PSLVERR_O |-> PREADY_O)
        else $error("error without ready");
    a_reset_idle: assert property (disable iff (1'b0) !RESETN_I |=> NORMAL_REQUEST_OUT_N_O && FAST_REQUEST_OUT_N_O)
        else $error("requests active after reset");
    a_gmask_quiet: assert property (general_mask_bit_reg [*3] |-> NORMAL_REQUEST_OUT_N_O && FAST_REQUEST_OUT_N_O)
        else $error("request active under general mask");
    a_req_needs_en: assert property (!NORMAL_REQUEST_OUT_N_O || !FAST_REQUEST_OUT_N_O |->
        (en_reg | $past(en_reg) | $past(en_reg, 2) | $past(en_reg, 3)) != 32'h0000_0000)
        else $error("request with no source enabled");
    a_cmd_read_zero: assert property (rd && (PADDR_I[31:4] == 28'hFFF_FF12 ||
        PADDR_I == `VIC_END_OF_SERVICE_COMMAND || PADDR_I == `VIC_FAST_FORCING_ENABLE_COMMAND)
        |-> PRDATA_O == 32'h0000_0000)
        else $error("command register read not zero");
    a_fast_spurious: assert property (rd && PADDR_I == `VIC_FAST_VECTOR_READ && en_reg == 32'h0000_0000
        |-> PRDATA_O == spur_reg)
        else $error("fast vector not spurious");
    a_norm_spurious: assert property (rd && PADDR_I == `VIC_NORMAL_VECTOR_READ && !used_reg
        |-> PRDATA_O == spur_reg)
        else $error("normal vector not spurious");
endmodule // icr_monitor
bind vic_top icr_monitor u_mon (.CLK_I(CLK_I), .RESETN_I(RESETN_I), .PADDR_I(PADDR_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
    .PSLVERR_O(PSLVERR_O), .PWDATA_I(PWDATA_I), .NORMAL_REQUEST_OUT_N_O(NORMAL_REQUEST_OUT_N_O),
    .FAST_REQUEST_OUT_N_O(FAST_REQUEST_OUT_N_O));

// *** icr_source_model.sv ***
`timescale 1ns/100ps
module icr_source_model (
    input wire clk_i,
    input wire [31:0] fire_i,
    output reg [31:0] src_o
);
    reg [2:0] hold_reg = 3'h0;
    initial src_o = 32'h0000_0000;
    // a fired source line stays high eight cycles, then drops
    always @(posedge clk_i) begin
        if (fire_i != 32'h0000_0000) begin
            src_o <= src_o | fire_i;
            hold_reg <= 3'h7;
        end else if (hold_reg != 3'h0) hold_reg <= hold_reg - 3'h1;
        else src_o <= 32'h0000_0000;
    end
endmodule // icr_source_model

// *** interrupt_command_registers_bench.sv ***
`timescale 1ns/100ps
`include "vic_regs.vh"
module interrupt_command_registers_bench;
    localparam [31:0] zero = 32'h0000_0000;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [31:0] paddr = zero;
    reg [31:0] pwdata = zero;
    reg [31:0] fire = zero;
    reg [31:0] rd, en, pend, spur, v;
    reg err;
    wire [31:0] prdata, src;
    wire pready, pslverr, nreq_n, freq_n;
    integer seed = 32'h908c;
    integer fail_count = 0;
    integer checks_done = 0;
    integer cyc = 0;
    integer i;
    initial forever #12.5 clk = ~clk;
    vic_top uut (.CLK_I(clk), .RESETN_I(rst_n), .PADDR_I(paddr), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .SOURCE_I(src), .NORMAL_REQUEST_OUT_N_O(nreq_n), .FAST_REQUEST_OUT_N_O(freq_n));
    icr_source_model u_src (.clk_i(clk), .fire_i(fire), .src_o(src));
    task close_out;
        begin
            $display("checks %0d mismatches %0d", checks_done, fail_count);
            if (fail_count == 0 && checks_done > 0) $display("RESULT: PASS");
            else $display("RESULT: FAIL");
            $finish;
        end
    endtask
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            fail_count = fail_count + 1;
            close_out;
        end
    end
    task chk(input [8*12:1] nm, input [31:0] e, input [31:0] g);
        begin
            checks_done = checks_done + 1;
            if (g !== e) begin
                fail_count = fail_count + 1;
                $display("[ERR] %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task apb(input reg w, input reg [31:0] a, input reg [31:0] d);
        begin
            @(posedge clk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clk);
            penable <= 1'b1;
            @(posedge clk);
            while (pready !== 1'b1) @(posedge clk);
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task rd_chk(input [31:0] a, input [31:0] e, input [8*12:1] nm);
        begin
            apb(1'b0, a, zero);
            chk(nm, e, rd);
        end
    endtask
    task req_chk(input [8*12:1] nm, input reg f, input reg e);
        integer k;
        begin
            for (k = 0; k < 12 && (f ? freq_n : nreq_n) !== e; k = k + 1) @(posedge clk);
            chk(nm, {31'h0, e}, {31'h0, f ? freq_n : nreq_n});
        end
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(`VIC_SOURCE_ENABLE_STATE, zero, "enable rst");
        rd_chk(`VIC_DEBUG_CONTROL, zero, "debug rst");
        spur = $random(seed);
        apb(1'b1, `VIC_SPURIOUS_VECTOR, spur);
        rd_chk(`VIC_SPURIOUS_VECTOR, spur, "spur rw");
        rd_chk(`VIC_NORMAL_VECTOR_READ, spur, "normal spur");
        rd_chk(`VIC_FAST_VECTOR_READ, spur, "fast spur");
        $display("test spurious done");
        en = zero;
        pend = zero;
        for (i = 0; i < 16; i = i + 1) begin
            v = (i < 2) ? 32'h8000_0003 : $random(seed);
            apb(1'b1, 32'hFFFF_F120 + {i[3], i[0], 2'h0}, v);
            en = i[3] ? en : (i[0] ? en & ~v : en | v);
            pend = !i[3] ? pend : (i[0] ? pend | v : pend & ~v);
            rd_chk(`VIC_SOURCE_ENABLE_STATE, en, "enable st");
            rd_chk(`VIC_PENDING_STATE, pend, "pending st");
        end
        $display("test commands done");
        for (i = 0; i < 6; i = i + 1) rd_chk(32'hFFFF_F120 + 4 * i, zero, "cmd read");
        rd_chk(`VIC_PENDING_STATE, pend, "no side fx");
        apb(1'b0, 32'hFFFF_F13C, zero);
        chk("unmapped", 32'h0000_0001, {31'h0, err});
        v = $random(seed);
        apb(1'b1, `VIC_FAST_FORCING_ENABLE_COMMAND, v);
        rd_chk(`VIC_FAST_FORCING_STATE, v & 32'hFFFF_FFFE, "force on");
        apb(1'b1, `VIC_FAST_FORCING_DISABLE_COMMAND, v);
        rd_chk(`VIC_FAST_FORCING_STATE, zero, "force off");
        $display("test reads and forcing done");
        apb(1'b1, `VIC_SOURCE_DISABLE_COMMAND, 32'hFFFF_FFFF);
        apb(1'b1, `VIC_PENDING_CLEAR_COMMAND, 32'hFFFF_FFFF);
        apb(1'b1, `VIC_DEBUG_CONTROL, 32'h0000_0003);
        rd_chk(`VIC_DEBUG_CONTROL, 32'h0000_0003, "debug rw");
        v = $random(seed);
        apb(1'b1, 32'hFFFF_F088, v);
        apb(1'b1, `VIC_SOURCE_ENABLE_COMMAND, 32'h0000_0005);
        apb(1'b1, `VIC_PENDING_SET_COMMAND, 32'h0000_0005);
        repeat (4) @(posedge clk);
        req_chk("masked n", 1'b0, 1'b1);
        req_chk("masked f", 1'b1, 1'b1);
        apb(1'b1, `VIC_DEBUG_CONTROL, zero);
        req_chk("normal on", 1'b0, 1'b0);
        req_chk("fast on", 1'b1, 1'b0);
        rd_chk(`VIC_NORMAL_VECTOR_READ, v, "vector src2");
        req_chk("in service", 1'b0, 1'b1);
        @(posedge clk) fire <= 32'h0000_0004;
        @(posedge clk) fire <= zero;
        apb(1'b1, `VIC_END_OF_SERVICE_COMMAND, $random(seed));
        req_chk("after eos", 1'b0, 1'b0);
        apb(1'b1, `VIC_DEBUG_CONTROL, 32'h0000_0001);
        rd_chk(`VIC_NORMAL_VECTOR_READ, v, "protection_mode_bit read");
        rd_chk(`VIC_PENDING_STATE, 32'h0000_0005, "protection_mode_bit no ack");
        apb(1'b1, `VIC_NORMAL_VECTOR_READ, zero);
        rd_chk(`VIC_PENDING_STATE, 32'h0000_0001, "protection_mode_bit ack");
        req_chk("protection_mode_bit serv", 1'b0, 1'b1);
        apb(1'b1, `VIC_DEBUG_CONTROL, zero);
        apb(1'b1, `VIC_SVR_BASE, ~v);
        rd_chk(`VIC_FAST_VECTOR_READ, ~v, "fast vector");
        req_chk("fast acked", 1'b1, 1'b1);
        $display("test request lines done");
        close_out;
    end
endmodule // interrupt_command_registers_bench
